// ===== logic/psm_fault_monitor.sv
// power stage fault monitor: gate steering, fault flags, shared temperature pin
// Notes on behaviour
// RULE_01 - before power ready, pull the temperature pin strongly low
// RULE_02 - temperature pin turns into a fault flag on overcurrent, overtemp or short
// RULE_03 - no fault: pin level is 0.6 V plus 8 mV per degree
// RULE_04 - any fault drives the pin to the 3.0 V rail
// RULE_05 - pin sources strongly and sinks weakly so shared line shows hottest
// RULE_06 - protection uses internal temperature, never the shared line
// RULE_07 - over-temperature flag sets above 140 degrees
// RULE_08 - over-temperature keeps gates following pwm, no tri-state
// RULE_09 - over-temperature flag clears below 125 degrees
// RULE_10 - current limit hit turns the high-side switch off at once
// RULE_11 - high-side stays off until current falls below release level
// RULE_12 - ten overcurrent cycles without three clean ones raise the fault flag
// RULE_13 - three clean cycles in a row release the overcurrent flag
// RULE_14 - overcurrent never shuts drivers down, only trims high-side on-time
// RULE_15 - high-side short raises fault, gates keep following pwm
// RULE_16 - short flag clears when gone, on supply loss or enable toggle
// RULE_17 - high output at power-up turns low-side on until it clears
// RULE_18 - reverse current trip turns low-side off regardless of pwm
// RULE_19 - resume pwm control when reverse current relaxes to -40 A
// RULE_20 - repeat trip and resume, regulating between -40 A and -60 A
// RULE_21 - power ready after 40 us from full, 10 us from partial shutdown
// RULE_22 - high gate in phase, low gate antiphase; both low when disabled; low gate still stays on while startup_ov_ff is set
// RULE_23 - fault indication is the or of the three fault flags
// RULE_24 - controller reads fault as the pin near its high rail
`timescale 1ns/1ps
`default_nettype none
module psm_fault_monitor #(
   parameter int TEMP_W = 10
) (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire psm_pkg::psm_cmd_type  cmd,
   input  wire psm_pkg::psm_sense_type sense,
   input  wire logic [TEMP_W-1:0]     die_temp_c,
   input  wire logic [3:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   output logic                       high_side_gate_drive,
   output logic                       low_side_gate_drive,
   output logic [11:0]                temp_fault_out,
   output logic                       temp_fault_source_strong,
   output logic                       temp_fault_sink_strong,
   output logic                       fault_flag,
   output logic                       power_ready
);
   import psm_pkg::*;

   if (TEMP_W < 9 || TEMP_W > 16) begin
      $error("psm_fault_monitor: TEMP_W must lie in 9..16");
   end

   psm_pwr_type              pwr_ff;
   psm_pwr_type              nxt_pwr;
   logic [STARTUP_CNT_W-1:0] start_cnt_ff;
   logic                     was_full_off_ff;
   logic                     ready_ff;

   logic                     overtemp_ff;
   logic                     overcur_ff;
   logic                     hs_short_ff;
   logic                     startup_ov_ff;
   logic                     hs_block_ff;
   logic                     reverse_block_ff;
   logic [3:0]               oc_cnt_ff;
   logic [3:0]               clean_run_ff;
   logic                     cycle_oc_ff;
   logic                     pwm_prev_ff;

   logic [7:0]               ot_set_ff;
   logic [7:0]               ot_clear_ff;
   logic [3:0]               oc_count_lim_ff;
   logic [3:0]               oc_run_lim_ff;

   logic [31:0]              readdata_ff;
   logic                     waitreq_ff;
   logic                     hs_gate_ff;
   logic                     ls_gate_ff;
   logic [11:0]              temp_out_ff;
   logic                     src_strong_ff;
   logic                     sink_strong_ff;
   logic                     fault_ff;

   logic                     cycle_start;
   logic                     drive_enabled;
   logic                     any_fault;
   logic [11:0]              temp_mv;
   logic                     bus_take;
   logic                     ready_next;

   // clamp die temperature into 0..255 degrees for the pin scale
   function automatic logic [7:0] clamp_temp(input logic [TEMP_W-1:0] t);
      logic [7:0] r;
      r = 8'h00;
      if (t[TEMP_W-1]) begin
         r = 8'h00;
      end else if (t[TEMP_W-2:0] > (TEMP_W-1)'(255)) begin
         r = 8'hFF;
      end else begin
         r = t[7:0];
      end
      return r;
   endfunction

   assign cycle_start   = cmd.pwm_high & ~pwm_prev_ff;
   assign drive_enabled = ready_ff & cmd.enable & ~cmd.pwm_tristate;
   assign any_fault     = overtemp_ff | overcur_ff | hs_short_ff; // RULE_23
   assign temp_mv       = TEMP_ZERO_MV
                          + TEMP_SLOPE_MV * {4'h0, clamp_temp(die_temp_c)}; // RULE_03
   assign bus_take      = (avs_read | avs_write) & ~waitreq_ff;
   assign ready_next    = (nxt_pwr == PWR_READY);

   // power-ready sequencing
   always_comb begin
      nxt_pwr = pwr_ff;
      case (pwr_ff)
         PWR_OFF: begin
            if (cmd.vcc_good && cmd.enable) begin
               nxt_pwr = PWR_START;
            end
         end
         PWR_START: begin
            if (!cmd.vcc_good || !cmd.enable) begin
               nxt_pwr = PWR_OFF;
            end else if ((was_full_off_ff
                          && start_cnt_ff == STARTUP_CNT_W'(FULL_STARTUP_CYC - 1))
                         || (!was_full_off_ff
                          && start_cnt_ff == STARTUP_CNT_W'(PART_STARTUP_CYC - 1))) begin
               nxt_pwr = PWR_READY; // RULE_21
            end
         end
         PWR_READY: begin
            if (!cmd.vcc_good || !cmd.enable) begin
               nxt_pwr = PWR_OFF;
            end
         end
         default: nxt_pwr = PWR_OFF;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pwr_ff <= PWR_OFF;
      end else begin
         pwr_ff <= nxt_pwr;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         start_cnt_ff    <= '0;
         was_full_off_ff <= 1'b1;
         ready_ff        <= 1'b0;
      end else begin
         ready_ff <= (nxt_pwr == PWR_READY);
         if (pwr_ff == PWR_START) begin
            start_cnt_ff <= start_cnt_ff + STARTUP_CNT_W'(1);
         end else begin
            start_cnt_ff <= '0;
         end
         // supply loss means full restart time, enable low only partial
         if (!cmd.vcc_good) begin
            was_full_off_ff <= 1'b1;
         end else if (pwr_ff == PWR_READY) begin
            was_full_off_ff <= 1'b0;
         end
      end
   end

   // over-temperature with hysteresis on the internal reading only
   always_ff @(posedge clk) begin
      if (reset) begin
         overtemp_ff <= 1'b0;
      end else if (clamp_temp(die_temp_c) > ot_set_ff) begin // RULE_06
         overtemp_ff <= 1'b1; // RULE_07
      end else if (clamp_temp(die_temp_c) < ot_clear_ff) begin
         overtemp_ff <= 1'b0; // RULE_09
      end
   end

   // cycle-by-cycle high-side cutoff
   always_ff @(posedge clk) begin
      if (reset) begin
         hs_block_ff <= 1'b0;
      end else if (sense.current_limit_hit) begin
         hs_block_ff <= 1'b1; // RULE_10
      end else if (sense.current_below_release) begin
         hs_block_ff <= 1'b0; // RULE_11
      end
   end

   // counted overcurrent flag, judged at each pwm rising edge
   always_ff @(posedge clk) begin
      if (reset) begin
         pwm_prev_ff  <= 1'b0;
         cycle_oc_ff  <= 1'b0;
         oc_cnt_ff    <= '0;
         clean_run_ff <= '0;
         overcur_ff   <= 1'b0;
      end else begin
         pwm_prev_ff <= cmd.pwm_high;
         if (cycle_start) begin
            // a hit in the boundary cycle counts for the new cycle
            cycle_oc_ff <= sense.current_limit_hit;
            if (cycle_oc_ff) begin
               clean_run_ff <= '0;
               if (oc_cnt_ff != 4'hF) begin
                  oc_cnt_ff <= oc_cnt_ff + 4'h1;
               end
               if (oc_cnt_ff + 4'h1 >= oc_count_lim_ff) begin
                  overcur_ff <= 1'b1; // RULE_12
               end
            end else begin
               if (clean_run_ff != 4'hF) begin
                  clean_run_ff <= clean_run_ff + 4'h1;
               end
               if (clean_run_ff + 4'h1 >= oc_run_lim_ff) begin
                  oc_cnt_ff  <= '0; // RULE_12
                  overcur_ff <= 1'b0; // RULE_13
               end
            end
         end else if (sense.current_limit_hit) begin
            cycle_oc_ff <= 1'b1;
         end
      end
   end

   // short flag follows detection, dropped by supply loss or enable low
   always_ff @(posedge clk) begin
      if (reset) begin
         hs_short_ff <= 1'b0;
      end else begin
         hs_short_ff <= sense.hs_short_detect & cmd.vcc_good & cmd.enable; // RULE_16
      end
   end

   // output over-voltage watch only while powering up
   always_ff @(posedge clk) begin
      if (reset) begin
         startup_ov_ff <= 1'b0;
      end else if (!sense.vout_high_detect || !cmd.vcc_good) begin
         startup_ov_ff <= 1'b0;
      end else if (pwr_ff == PWR_START) begin
         startup_ov_ff <= 1'b1; // RULE_17
      end
   end

   // reverse current hiccup: trip at -60 A, resume at -40 A
   always_ff @(posedge clk) begin
      if (reset) begin
         reverse_block_ff <= 1'b0;
      end else if (sense.reverse_current_trip) begin
         reverse_block_ff <= 1'b1; // RULE_18
      end else if (sense.reverse_current_relaxed) begin
         reverse_block_ff <= 1'b0; // RULE_19 RULE_20
      end
   end

   // gate steering; faults never tri-state the drivers
   always_ff @(posedge clk) begin
      if (reset) begin
         hs_gate_ff <= 1'b0;
         ls_gate_ff <= 1'b0;
      end else begin
         hs_gate_ff <= drive_enabled & cmd.pwm_high & ~hs_block_ff
                       & ~sense.current_limit_hit
                       & ~startup_ov_ff; // RULE_22 RULE_10 RULE_14 RULE_08 RULE_15
         ls_gate_ff <= startup_ov_ff
                       | (drive_enabled & ~cmd.pwm_high
                          & ~sense.reverse_current_trip
                          & ~reverse_block_ff); // RULE_17 RULE_22 RULE_18 RULE_19
      end
   end

   // shared temperature-or-fault pin
   always_ff @(posedge clk) begin
      if (reset) begin
         temp_out_ff    <= '0;
         src_strong_ff  <= 1'b0;
         sink_strong_ff <= 1'b1;
         fault_ff       <= 1'b0;
      end else begin
         // next ready, so the pin drops in the same cycle as power_ready
         fault_ff <= ready_next & any_fault; // RULE_02
         if (!ready_next) begin
            temp_out_ff    <= '0; // RULE_01
            src_strong_ff  <= 1'b0;
            sink_strong_ff <= 1'b1; // RULE_01
         end else begin
            // sinking stays weak so the hottest module wins the line
            src_strong_ff  <= 1'b1; // RULE_05
            sink_strong_ff <= 1'b0; // RULE_05
            if (any_fault) begin
               temp_out_ff <= FAULT_RAIL_MV; // RULE_04 RULE_24
            end else begin
               temp_out_ff <= temp_mv; // RULE_03
            end
         end
      end
   end

   // avalon slave: one wait cycle, then the answer
   always_ff @(posedge clk) begin
      if (reset) begin
         waitreq_ff  <= 1'b1;
         readdata_ff <= '0;
      end else if (bus_take) begin
         waitreq_ff <= 1'b1;
      end else if (avs_read || avs_write) begin
         waitreq_ff  <= 1'b0;
         readdata_ff <= '0;
         if (avs_read) begin
            case (avs_address)
               ADDR_STATUS: begin
                  readdata_ff[ST_OVERTEMP]             <= overtemp_ff;
                  readdata_ff[ST_OVERCUR]              <= overcur_ff;
                  readdata_ff[ST_HS_SHORT]             <= hs_short_ff;
                  readdata_ff[ST_STARTUP]              <= startup_ov_ff;
                  readdata_ff[ST_REVERSE]              <= reverse_block_ff;
                  readdata_ff[ST_HS_BLOCK]             <= hs_block_ff;
                  readdata_ff[ST_PWR_READY]            <= ready_ff;
                  readdata_ff[ST_OC_CNT+3:ST_OC_CNT]   <= oc_cnt_ff;
               end
               ADDR_TEMP: begin
                  readdata_ff[7:0]                     <= clamp_temp(die_temp_c);
                  readdata_ff[TEMP_MV_LSB+11:TEMP_MV_LSB] <= temp_out_ff;
               end
               ADDR_OT_THRESH: begin
                  readdata_ff[OT_SET_LSB+7:OT_SET_LSB]     <= ot_set_ff;
                  readdata_ff[OT_CLEAR_LSB+7:OT_CLEAR_LSB] <= ot_clear_ff;
               end
               ADDR_OC_LIMIT: begin
                  readdata_ff[OC_COUNT_LSB+3:OC_COUNT_LSB] <= oc_count_lim_ff;
                  readdata_ff[OC_RUN_LSB+3:OC_RUN_LSB]     <= oc_run_lim_ff;
               end
               default: readdata_ff <= '0;
            endcase
         end
      end
   end

   // writable thresholds; zero limits would make the counters meaningless
   always_ff @(posedge clk) begin
      if (reset) begin
         ot_set_ff       <= OT_SET_RST;
         ot_clear_ff     <= OT_CLEAR_RST;
         oc_count_lim_ff <= OC_COUNT_RST;
         oc_run_lim_ff   <= OC_RUN_RST;
      end else if (bus_take && avs_write) begin
         case (avs_address)
            ADDR_OT_THRESH: begin
               ot_set_ff   <= avs_writedata[OT_SET_LSB+7:OT_SET_LSB];
               ot_clear_ff <= avs_writedata[OT_CLEAR_LSB+7:OT_CLEAR_LSB];
            end
            ADDR_OC_LIMIT: begin
               if (avs_writedata[OC_COUNT_LSB+3:OC_COUNT_LSB] != 4'h0) begin
                  oc_count_lim_ff <= avs_writedata[OC_COUNT_LSB+3:OC_COUNT_LSB];
               end
               if (avs_writedata[OC_RUN_LSB+3:OC_RUN_LSB] != 4'h0) begin
                  oc_run_lim_ff <= avs_writedata[OC_RUN_LSB+3:OC_RUN_LSB];
               end
            end
            default: begin
            end
         endcase
      end
   end

   assign avs_readdata             = readdata_ff;
   assign avs_waitrequest          = waitreq_ff;
   assign high_side_gate_drive     = hs_gate_ff;
   assign low_side_gate_drive      = ls_gate_ff;
   assign temp_fault_out           = temp_out_ff;
   assign temp_fault_source_strong = src_strong_ff;
   assign temp_fault_sink_strong   = sink_strong_ff;
   assign fault_flag               = fault_ff;
   assign power_ready              = ready_ff;
endmodule
`default_nettype wire

// ===== logic/psm_pkg.sv
// shared constants and types of the power stage fault monitor
package psm_pkg;
   localparam int CLK_MHZ          = 50;
   localparam int FULL_STARTUP_US  = 40;
   localparam int PART_STARTUP_US  = 10;
   localparam int FULL_STARTUP_CYC = FULL_STARTUP_US * CLK_MHZ;
   localparam int PART_STARTUP_CYC = PART_STARTUP_US * CLK_MHZ;
   localparam int STARTUP_CNT_W    = 12;

   // temperature output in millivolts
   localparam logic [11:0] TEMP_ZERO_MV   = 12'h258;
   localparam logic [11:0] TEMP_SLOPE_MV  = 12'h008;
   localparam logic [11:0] FAULT_RAIL_MV  = 12'hBB8;

   localparam logic [7:0] OT_SET_RST      = 8'h8C;
   localparam logic [7:0] OT_CLEAR_RST    = 8'h7D;
   localparam logic [3:0] OC_COUNT_RST    = 4'hA;
   localparam logic [3:0] OC_RUN_RST      = 4'h3;

   localparam logic [3:0] ADDR_STATUS     = 4'h0;
   localparam logic [3:0] ADDR_TEMP       = 4'h4;
   localparam logic [3:0] ADDR_OT_THRESH  = 4'h8;
   localparam logic [3:0] ADDR_OC_LIMIT   = 4'hC;

   localparam int OT_SET_LSB   = 0;
   localparam int OT_CLEAR_LSB = 8;
   localparam int OC_COUNT_LSB = 0;
   localparam int OC_RUN_LSB   = 4;
   localparam int TEMP_MV_LSB  = 16;

   localparam int ST_OVERTEMP  = 0;
   localparam int ST_OVERCUR   = 1;
   localparam int ST_HS_SHORT  = 2;
   localparam int ST_STARTUP   = 3;
   localparam int ST_REVERSE   = 4;
   localparam int ST_HS_BLOCK  = 5;
   localparam int ST_PWR_READY = 6;
   localparam int ST_OC_CNT    = 8;

   typedef struct packed {
      logic current_limit_hit;
      logic current_below_release;
      logic hs_short_detect;
      logic vout_high_detect;
      logic reverse_current_trip;
      logic reverse_current_relaxed;
   } psm_sense_type;

   typedef struct packed {
      logic enable;
      logic pwm_high;
      logic pwm_tristate;
      logic vcc_good;
   } psm_cmd_type;

   typedef enum logic [2:0] {
      PWR_OFF   = 3'b001,
      PWR_START = 3'b010,
      PWR_READY = 3'b100
   } psm_pwr_type;
endpackage

// ===== testbench/psm_ctrl_model.sv
// controller model: pwm, enable and supply pins, reads the shared pin
`timescale 1ns/1ps
`default_nettype none
module psm_ctrl_model (
   input  wire logic              clk,
   input  wire logic              run,
   input  wire logic              en_req,
   input  wire logic              vcc_req,
   input  wire logic              tri_req,
   input  wire logic [11:0]       pin_mv,
   output var psm_pkg::psm_cmd_type cmd,
   output logic                   cyc_start,
   output logic                   saw_fault
);
   import psm_pkg::*;
   int phase = 0;
   // fixed 8-cycle period, high for 4; stopped pwm sits low
   always @(posedge clk) begin
      phase <= run ? (phase + 1) % 8 : 0;
      cmd.pwm_high <= run && phase < 4;
      cyc_start <= run && phase == 0;
      cmd.enable <= en_req;
      cmd.vcc_good <= vcc_req;
      cmd.pwm_tristate <= tri_req;
   end
   // any level well above the hottest valid reading means fault
   assign saw_fault = pin_mv > 12'hAF0;
endmodule
`default_nettype wire

// ===== testbench/psm_fault_monitor_bench.sv
// self-checking bench of the fault monitor against a behavioural model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
   $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module psm_fault_monitor_bench;
   import psm_pkg::*;
   logic                  clk = 1'b0, reset = 1'b1, run = 1'b0, tri_req = 1'b0;
   logic                  en_req = 1'b1, vcc_req = 1'b1, cyc_start, saw_fault;
   psm_cmd_type           cmd;
   psm_sense_type         sense = 6'h11;
   logic [9:0]            die_temp_c = 10'h019;
   logic [3:0]            avs_address = 4'h0;
   logic                  avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0]           avs_writedata = 32'h0, avs_readdata;
   logic                  avs_waitrequest, high_side_gate_drive, low_side_gate_drive;
   logic [11:0]           temp_fault_out;
   logic                  temp_fault_source_strong, temp_fault_sink_strong;
   logic                  fault_flag, power_ready;
   int                    miscompares = 0, n_compared = 0;
   int                    ot_t[4] = '{140, 141, 125, 124};
   bit                    ot_f[4] = '{0, 1, 1, 0};
   psm_fault_monitor #(.TEMP_W(10)) psm_fault_monitor_i (
      .clk(clk), .reset(reset), .cmd(cmd), .sense(sense), .die_temp_c(die_temp_c),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .high_side_gate_drive(high_side_gate_drive),
      .low_side_gate_drive(low_side_gate_drive), .temp_fault_out(temp_fault_out),
      .temp_fault_source_strong(temp_fault_source_strong),
      .temp_fault_sink_strong(temp_fault_sink_strong), .fault_flag(fault_flag),
      .power_ready(power_ready));
   psm_ctrl_model psm_ctrl_model_i (
      .clk(clk), .run(run), .en_req(en_req), .vcc_req(vcc_req), .tri_req(tri_req),
      .pin_mv(temp_fault_out), .cmd(cmd), .cyc_start(cyc_start), .saw_fault(saw_fault));
   initial begin
      forever #10 clk = ~clk;
   end
   function automatic int exp_pin(int t, bit f);
      return f ? 3000 : 600 + 8 * t;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // request held until waitrequest is sampled low at an edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic follow();
      @(posedge clk iff cyc_start);
      tick(2);
      `CHK("hs_on", 1'b1, high_side_gate_drive)
      `CHK("ls_off", 1'b0, low_side_gate_drive)
      tick(4);
      `CHK("ls_on", 1'b1, low_side_gate_drive)
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
   initial begin
      logic [31:0] q;
      logic [24:0] pat;
      int          n, t, cnt, clean;
      bit          flg;
      void'($urandom(32'h9f8b));
      tick(12);
      reset <= 1'b0;
      n = 0;
      while (power_ready !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
         if (n == 1990) begin
            `CHK("pin_unready", 12'h000, temp_fault_out)
            `CHK("sink_unready", 1'b1, temp_fault_sink_strong)
         end
      end
      `CHK("ready_full", 1'b1, n >= 2000 && n <= 2003)
      run <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         t = $urandom_range(124, 0);
         die_temp_c <= 10'(t);
         tick(4);
         `CHK("temp_pin", 12'(exp_pin(t, 0)), temp_fault_out)
         `CHK("source", 1'b1, temp_fault_source_strong)
         `CHK("sink", 1'b0, temp_fault_sink_strong)
      end
      foreach (ot_t[i]) begin
         die_temp_c <= 10'(ot_t[i]);
         tick(4);
         `CHK("ot_flag", ot_f[i], fault_flag)
         `CHK("ot_pin", 12'(exp_pin(ot_t[i], ot_f[i])), temp_fault_out)
         `CHK("ot_seen", ot_f[i], saw_fault)
         follow();
      end
      // nine hits, three clean, ten hits, three clean
      pat = 25'h1FF1FF8;
      cnt = 0;
      clean = 0;
      flg = 0;
      for (int i = 24; i >= -1; i--) begin
         @(posedge clk iff cyc_start);
         if (i >= 0) begin
            sense.current_limit_hit <= pat[i];
            sense.current_below_release <= !pat[i];
         end
         @(posedge clk);
         sense.current_limit_hit <= 1'b0;
         tick(2);
         `CHK("oc_flag", flg, fault_flag)
         if (i < 0) break;
         `CHK("hs_block", !pat[i], high_side_gate_drive)
         sense.current_below_release <= 1'b1;
         clean = pat[i] ? 0 : clean + 1;
         cnt = pat[i] ? cnt + 1 : (clean >= 3 ? 0 : cnt);
         flg = (cnt >= 10) || (flg && clean < 3);
      end
      sense.hs_short_detect <= 1'b1;
      follow();
      `CHK("short_flag", 1'b1, fault_flag)
      sense.hs_short_detect <= 1'b0;
      tick(4);
      `CHK("short_clear", 1'b0, fault_flag)
      run <= 1'b0;
      tick(3);
      for (int i = 0; i < 3; i++) begin
         sense.reverse_current_trip <= 1'b1;
         sense.reverse_current_relaxed <= 1'b0;
         tick(2);
         `CHK("rev_cut", 1'b0, low_side_gate_drive)
         sense.reverse_current_trip <= 1'b0;
         tick(3);
         `CHK("rev_hold", 1'b0, low_side_gate_drive)
         sense.reverse_current_relaxed <= 1'b1;
         tick(3);
         `CHK("rev_resume", 1'b1, low_side_gate_drive)
      end
      tri_req <= 1'b1;
      tick(4);
      `CHK("tri_ls", 1'b0, low_side_gate_drive)
      tri_req <= 1'b0;
      en_req <= 1'b0;
      tick(4);
      `CHK("off_pin", 12'h000, temp_fault_out)
      en_req <= 1'b1;
      sense.vout_high_detect <= 1'b1;
      tick(10);
      `CHK("preov_ls", 1'b1, low_side_gate_drive)
      sense.vout_high_detect <= 1'b0;
      n = 10;
      while (power_ready !== 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      `CHK("ready_part", 1'b1, n >= 500 && n <= 504)
      bus(0, ADDR_STATUS, 32'h0, q);
      `CHK("status_ready", 1'b1, q[ST_PWR_READY])
      bus(0, ADDR_TEMP, 32'h0, q);
      `CHK("temp_reg", 32'h0638007C, q)
      bus(0, ADDR_OT_THRESH, 32'h0, q);
      `CHK("ot_thresh", 32'h00007D8C, q)
      bus(1, ADDR_OC_LIMIT, 32'h00000035, q);
      bus(0, ADDR_OC_LIMIT, 32'h0, q);
      `CHK("oc_limit", 32'h00000035, q)
      bus(1, 4'h2, 32'hFFFFFFFF, q);
      bus(0, 4'h2, 32'h0, q);
      `CHK("unmapped", 32'h00000000, q)
      give_verdict();
   end
endmodule
`default_nettype wire

// ===== testbench/psm_fault_monitor_chk.sv
// port assertions of the fault monitor
`timescale 1ns/1ps
`default_nettype none
module psm_fault_monitor_chk #(
   parameter int TEMP_W = 10
) (
   input wire logic                   clk,
   input wire logic                   reset,
   input wire psm_pkg::psm_cmd_type   cmd,
   input wire psm_pkg::psm_sense_type sense,
   input wire logic [TEMP_W-1:0]      die_temp_c,
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic                   avs_waitrequest,
   input wire logic                   high_side_gate_drive,
   input wire logic                   low_side_gate_drive,
   input wire logic [11:0]            temp_fault_out,
   input wire logic                   temp_fault_sink_strong,
   input wire logic                   fault_flag,
   input wire logic                   power_ready
);
   import psm_pkg::*;
   int unsigned on_cnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // cycles with enable and supply both good; any gap restarts it
   always_ff @(posedge clk) begin
      if (reset || !(cmd.enable && cmd.vcc_good)) begin
         on_cnt <= 0;
      end else begin
         on_cnt <= on_cnt + 1;
      end
   end
   sequence s_hot;
      (power_ready && $signed(die_temp_c) > 140)[*3];
   endsequence
   sequence s_fault2;
      (fault_flag && power_ready)[*2];
   endsequence
   sequence s_bus_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_pin_unready:
      assert property (!power_ready |-> temp_fault_out == 12'h000 && temp_fault_sink_strong)
      else $error("pin not low before ready");
   a_fault_rail:
      assert property (s_fault2 |-> temp_fault_out == FAULT_RAIL_MV)
      else $error("fault not on high rail");
   a_ot_sets:
      assert property (s_hot |-> fault_flag) else $error("hot die without fault");
   a_gates_excl:
      assert property (!(high_side_gate_drive && low_side_gate_drive))
      else $error("both gates on");
   a_gates_disabled:
      assert property (!cmd.enable || cmd.pwm_tristate |=>
         !high_side_gate_drive && !low_side_gate_drive) else $error("gate on while off");
   a_hs_cutoff:
      assert property (sense.current_limit_hit |=> !high_side_gate_drive)
      else $error("high gate kept on at limit");
   a_gate_phase:
      assert property (power_ready && cmd.enable && !cmd.pwm_tristate |=>
         ($past(cmd.pwm_high) ? !low_side_gate_drive : !high_side_gate_drive))
      else $error("gate against pwm");
   a_ls_reverse:
      assert property (sense.reverse_current_trip |=> !low_side_gate_drive)
      else $error("low gate on at reverse trip");
   a_ready_delay:
      assert property ($rose(power_ready) |-> on_cnt + 2 >= PART_STARTUP_CYC)
      else $error("ready too early");
   a_bus_answer:
      assert property ((avs_read || avs_write) && avs_waitrequest |=> s_bus_ack)
      else $error("bus answer not one cycle");
endmodule
bind psm_fault_monitor psm_fault_monitor_chk #(.TEMP_W(TEMP_W)) psm_fault_monitor_chk_i (
   .clk(clk), .reset(reset), .cmd(cmd), .sense(sense), .die_temp_c(die_temp_c),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .high_side_gate_drive(high_side_gate_drive), .low_side_gate_drive(low_side_gate_drive),
   .temp_fault_out(temp_fault_out), .temp_fault_sink_strong(temp_fault_sink_strong),
   .fault_flag(fault_flag), .power_ready(power_ready));
`default_nettype wire
